/* File: hdl/ioc_pkg.sv */
// Constants and types shared by the internal oscillator control block
package ioc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // Fast oscillator settle time after start or frequency change
  localparam int FAST_LOCK_NS = 2000;
  localparam int FAST_LOCK_CYC = (FAST_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_W = 8;
  localparam logic [LOCK_W-1:0] LOCK_LOAD = LOCK_W'(FAST_LOCK_CYC);
  // Output rates
  localparam int SLOW_HZ = 31_000;
  localparam int CONV_HZ = 600_000;
  localparam int MID_HZ = 500_000;
  localparam int MID_LOW_HZ_X100 = 3_125_000;
  localparam int FIXED_HZ = 1_000_000;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] SLOW_DIV = DIV_W'(CLK_HZ / SLOW_HZ);
  localparam logic [DIV_W-1:0] CONV_DIV = DIV_W'(CLK_HZ / CONV_HZ);
  localparam logic [DIV_W-1:0] MID_DIV1 = DIV_W'(FIXED_HZ / MID_HZ);
  localparam logic [DIV_W-1:0] MID_LOW_DIV = DIV_W'(MID_HZ * 100 / MID_LOW_HZ_X100);
  localparam logic [DIV_W-1:0] FIX_DIV1 = DIV_W'(FIXED_HZ / FIXED_HZ);
  // Phase accumulator of the fast oscillator
  localparam int ACC_W = 24;
  localparam logic [ACC_W-1:0] INC_1MHZ = ACC_W'((64'd1 << ACC_W) / CLK_MHZ);
  localparam int TRIM_SHIFT = 8;
  localparam logic [ACC_W-1:0] SLEW = 24'h00_0040;
  // Register indices; byte address is four times the index
  localparam int ADDR_W = 14;
  localparam logic [11:0] IDX_SRC = 12'h88e;
  localparam logic [11:0] IDX_STAT = 12'h890;
  localparam logic [11:0] IDX_EN = 12'h891;
  localparam logic [11:0] IDX_TRIM = 12'h892;
  localparam logic [11:0] IDX_FRQ = 12'h893;
  // Bit positions in status and enable registers
  localparam int BIT_FAST = 6;
  localparam int BIT_MID = 5;
  localparam int BIT_SLOW = 4;
  localparam int BIT_CONV = 2;
  localparam int BIT_FIXED = 1;
  localparam int SRC_LSB = 4;
  // Index into the ready vector and the enable vector
  localparam int R_FAST = 0;
  localparam int R_MID = 1;
  localparam int R_SLOW = 2;
  localparam int R_CONV = 3;
  localparam int R_FIXED = 4;
  // Reset values and codes
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [3:0] EN_RST = 4'h0;
  localparam logic [2:0] FRQ_1M = 3'h0;
  localparam logic [2:0] FRQ_32M = 3'h5;
  localparam logic [2:0] FRQ_MAX = 3'h5;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [1:0] SRC_HF1M = 2'h2;
  localparam logic [1:0] SRC_LF = 2'h1;
  localparam logic [1:0] SRC_HF32M = 2'h0;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_SRC,
    REG_STAT,
    REG_EN,
    REG_TRIM,
    REG_FRQ
  } ioc_reg_t;
endpackage

/* File: hdl/ioc_div_chan.sv */
// Tick divider with run gating and ready flag for one derived clock
module ioc_div_chan (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic src_ok,
  input wire logic src_tick,
  input wire logic [ioc_pkg::DIV_W-1:0] ratio,
  output logic tick,
  output logic ready
);
  import ioc_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
    logic ready;
  } ioc_chan_t;

  ioc_chan_t s_q;
  ioc_chan_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run || !src_ok) begin
      s_d.cnt = '0;
      s_d.ready = 1'b0;
    end else if (src_tick) begin
      // Compare with >= so a shrinking ratio cannot overrun
      if (s_q.cnt >= ratio - DIV_W'(1)) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
        s_d.ready = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
  assign ready = s_q.ready;

  a_ready_needs_run: assert property (
    @(posedge clk) disable iff (!nrst)
    !run |=> !ready)
    else $error("ready flag set while oscillator stopped");
endmodule

/* File: hdl/ioc_osc_ctrl.sv */
// Internal oscillator control: registers, fast oscillator model, dividers
// Behaviour
// - Three-bit frequency select, codes six and seven reserved
// - Six-bit signed trim, resets to zero
// - Positive trim raises, negative trim lowers frequency
// - Trim changes slew gradually, no completion flag
// - Trim never touches the slow oscillator
// - Mid clocks 500k and 31.25k, fixed rates
// - Mid clocks never drive the system clock
// - Fixed 1 MHz clock, peripherals only
// - Slow 31 kHz clock, system and timers
// - Converter RC starts on request or enable
// - Converter RC keeps running during sleep
// - Ready flags set when running, zero otherwise
// - Frequency select write clears fast ready
// - Fast output frozen until new frequency locks
// - Manual enables force oscillators on
// - Read-only source field at bits 5:4
// - Fast is system clock only by configuration
// - Reset configuration loads source and frequency
// - Software cannot change system clock source
module ioc_osc_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ioc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] reset_source_config,
  input wire logic sleep_mode,
  input wire logic fast_osc_req,
  input wire logic mid_osc_req,
  input wire logic fixed_osc_req,
  input wire logic slow_osc_req,
  input wire logic powerup_timer_req,
  input wire logic watchdog_timer_req,
  input wire logic conv_rc_req,
  output logic fast_osc_tick,
  output logic fast_osc_lvl,
  output logic mid_500k_tick,
  output logic mid_31k_tick,
  output logic fixed_1mhz_tick,
  output logic slow_osc_tick,
  output logic conv_rc_tick,
  output logic sysclk_tick
);
  import ioc_pkg::*;

  typedef struct packed {
    logic cfg_done;
    logic [1:0] src;
    logic [2:0] sel;
    logic [5:0] trim;
    logic [3:0] men;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] inc;
    logic [LOCK_W-1:0] lock;
    logic run;
    logic lvl;
    logic tick;
    logic [4:0] rs1;
    logic [4:0] rs2;
    logic ack;
    logic [7:0] rdata;
    logic sys;
  } ioc_state_t;

  ioc_state_t s_q;
  ioc_state_t s_d;

  function automatic ioc_reg_t reg_of(input logic [ADDR_W-1:0] a);
    logic [11:0] i;
    i = a[ADDR_W-1:2];
    if (i == IDX_SRC) begin
      reg_of = REG_SRC;
    end else if (i == IDX_STAT) begin
      reg_of = REG_STAT;
    end else if (i == IDX_EN) begin
      reg_of = REG_EN;
    end else if (i == IDX_TRIM) begin
      reg_of = REG_TRIM;
    end else if (i == IDX_FRQ) begin
      reg_of = REG_FRQ;
    end else begin
      reg_of = REG_NONE;
    end
  endfunction

  logic sys_fast;
  logic sys_slow;
  logic run_fast;
  logic run_mid;
  logic run_fix;
  logic run_slow;
  logic run_conv;
  logic fast_rdy;
  logic [4:0] rdy_raw;
  logic [DIV_W-1:0] mid_ratio;
  logic [DIV_W-1:0] fix_ratio;
  logic [ACC_W-1:0] base;
  logic [ACC_W-1:0] target;
  logic [25:0] prod;
  logic [25:0] tgt;
  logic [ACC_W:0] sum;
  logic req;
  logic wr_fire;
  ioc_reg_t rd_reg;
  ioc_reg_t wr_reg;
  logic [7:0] rval;
  logic mid_rdy;
  logic mid31_rdy;
  logic fix_rdy;
  logic slow_rdy;
  logic conv_rdy;

  // Demand for each oscillator
  always_comb begin
    sys_fast = s_q.cfg_done && !sleep_mode &&
      (s_q.src == SRC_HF1M || s_q.src == SRC_HF32M);
    sys_slow = s_q.cfg_done && !sleep_mode && (s_q.src == SRC_LF);
    run_mid = s_q.men[R_MID] | mid_osc_req;
    run_fix = fixed_osc_req;
    run_fast = s_q.men[R_FAST] | fast_osc_req | run_mid | run_fix | sys_fast;
    run_slow = s_q.men[R_SLOW] | slow_osc_req | sys_slow |
      powerup_timer_req | watchdog_timer_req;
    // Not gated by sleep so conversions continue
    run_conv = s_q.men[R_CONV] | conv_rc_req;
  end

  // Fixed output rates whatever the fast frequency
  assign mid_ratio = DIV_W'(MID_DIV1 << s_q.sel);
  assign fix_ratio = DIV_W'(FIX_DIV1 << s_q.sel);
  assign fast_rdy = s_q.run && (s_q.lock == '0);

  // Trimmed accumulator increment
  always_comb begin
    base = ACC_W'(INC_1MHZ << s_q.sel);
    prod = {{20{s_q.trim[5]}}, s_q.trim} * {2'b00, (base >> TRIM_SHIFT)};
    tgt = {2'b00, base} + prod;
    target = tgt[ACC_W-1:0];
  end

  assign req = avs_read | avs_write;
  assign wr_fire = avs_write && s_q.ack;
  assign rd_reg = reg_of(avs_address);
  assign wr_reg = reg_of(avs_address);

  always_comb begin
    rval = 8'h00;
    case (rd_reg)
      REG_SRC: rval[SRC_LSB +: 2] = s_q.src;
      REG_STAT: begin
        // Fast flag also masked locally so a fresh select write reads low
        rval[BIT_FAST] = s_q.rs2[R_FAST] && (s_q.lock == '0);
        rval[BIT_MID] = s_q.rs2[R_MID];
        rval[BIT_SLOW] = s_q.rs2[R_SLOW];
        rval[BIT_CONV] = s_q.rs2[R_CONV];
        rval[BIT_FIXED] = s_q.rs2[R_FIXED];
      end
      REG_EN: begin
        rval[BIT_FAST] = s_q.men[R_FAST];
        rval[BIT_MID] = s_q.men[R_MID];
        rval[BIT_SLOW] = s_q.men[R_SLOW];
        rval[BIT_CONV] = s_q.men[R_CONV];
      end
      REG_TRIM: rval = {2'b00, s_q.trim};
      REG_FRQ: rval = {5'b00000, s_q.sel};
      default: rval = 8'h00;
    endcase
  end

  assign rdy_raw[R_FAST] = fast_rdy;
  assign rdy_raw[R_MID] = mid_rdy & mid31_rdy;
  assign rdy_raw[R_SLOW] = slow_rdy;
  assign rdy_raw[R_CONV] = conv_rdy;
  assign rdy_raw[R_FIXED] = fix_rdy;

  always_comb begin
    s_d = s_q;
    sum = '0;
    // Capture the reset configuration once after release
    if (!s_q.cfg_done) begin
      s_d.cfg_done = 1'b1;
      s_d.src = reset_source_config;
      s_d.sel = (reset_source_config == SRC_HF32M) ? FRQ_32M : FRQ_1M;
    end
    s_d.run = run_fast;
    s_d.tick = 1'b0;
    if (!run_fast) begin
      s_d.lock = '0;
    end else if (!s_q.run) begin
      s_d.lock = LOCK_LOAD;
      s_d.inc = target;
    end else if (s_q.lock != '0) begin
      // Output held at its level while locking
      s_d.lock = s_q.lock - LOCK_W'(1);
      s_d.inc = target;
    end else begin
      sum = {1'b0, s_q.acc} + {1'b0, s_q.inc};
      s_d.acc = sum[ACC_W-1:0];
      s_d.tick = sum[ACC_W];
      s_d.lvl = s_q.lvl ^ sum[ACC_W];
      // Walk toward the trimmed rate in small steps
      if (s_q.inc + SLEW < target) begin
        s_d.inc = s_q.inc + SLEW;
      end else if (s_q.inc > target + SLEW) begin
        s_d.inc = s_q.inc - SLEW;
      end else begin
        s_d.inc = target;
      end
    end
    // Register writes on the accepting edge only
    if (wr_fire && avs_byteenable[0]) begin
      case (wr_reg)
        REG_EN: begin
          s_d.men[R_FAST] = avs_writedata[BIT_FAST];
          s_d.men[R_MID] = avs_writedata[BIT_MID];
          s_d.men[R_SLOW] = avs_writedata[BIT_SLOW];
          s_d.men[R_CONV] = avs_writedata[BIT_CONV];
        end
        REG_TRIM: s_d.trim = avs_writedata[5:0];
        REG_FRQ: begin
          // Reserved codes are ignored
          if (avs_writedata[2:0] <= FRQ_MAX) begin
            s_d.sel = avs_writedata[2:0];
            s_d.lock = LOCK_LOAD;
          end
        end
        // Source field has no write path
        default: s_d.src = s_q.src;
      endcase
    end
    // One wait cycle, then the answer
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack) begin
      s_d.rdata = avs_read ? rval : 8'h00;
    end
    s_d.rs1 = rdy_raw;
    s_d.rs2 = s_q.rs1;
    // Only fast or slow may clock the system
    case (s_q.src)
      SRC_HF1M, SRC_HF32M: s_d.sys = sys_fast && s_q.tick;
      SRC_LF: s_d.sys = sys_slow && slow_osc_tick;
      default: s_d.sys = 1'b0;
    endcase
    if (!s_q.cfg_done) begin
      s_d.sys = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.trim <= TRIM_RST;
      s_q.men <= EN_RST;
      s_q.sel <= FRQ_1M;
      s_q.src <= SRC_HF32M;
    end else begin
      s_q <= s_d;
    end
  end

  ioc_div_chan u_mid (
    .clk(clk),
    .nrst(nrst),
    .run(run_mid),
    .src_ok(fast_rdy),
    .src_tick(s_q.tick),
    .ratio(mid_ratio),
    .tick(mid_500k_tick),
    .ready(mid_rdy)
  );

  ioc_div_chan u_mid31 (
    .clk(clk),
    .nrst(nrst),
    .run(run_mid),
    .src_ok(mid_rdy),
    .src_tick(mid_500k_tick),
    .ratio(MID_LOW_DIV),
    .tick(mid_31k_tick),
    .ready(mid31_rdy)
  );

  ioc_div_chan u_fix (
    .clk(clk),
    .nrst(nrst),
    .run(run_fix),
    .src_ok(fast_rdy),
    .src_tick(s_q.tick),
    .ratio(fix_ratio),
    .tick(fixed_1mhz_tick),
    .ready(fix_rdy)
  );

  // Slow and converter clocks run from their own dividers, untrimmed
  ioc_div_chan u_slow (
    .clk(clk),
    .nrst(nrst),
    .run(run_slow),
    .src_ok(1'b1),
    .src_tick(1'b1),
    .ratio(SLOW_DIV),
    .tick(slow_osc_tick),
    .ready(slow_rdy)
  );

  ioc_div_chan u_conv (
    .clk(clk),
    .nrst(nrst),
    .run(run_conv),
    .src_ok(1'b1),
    .src_tick(1'b1),
    .ratio(CONV_DIV),
    .tick(conv_rc_tick),
    .ready(conv_rdy)
  );

  assign fast_osc_tick = s_q.tick;
  assign fast_osc_lvl = s_q.lvl;
  assign sysclk_tick = s_q.sys;
  assign avs_readdata = {24'h00_0000, s_q.rdata};
  assign avs_waitrequest = req && !s_q.ack;

  a_frq_clears_rdy: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_fire && avs_byteenable[0] && wr_reg == REG_FRQ && avs_writedata[2:0] <= FRQ_MAX)
    |=> (s_q.lock != '0 && !fast_rdy) [*8])
    else $error("fast ready not cleared after select write");

  a_lock_freezes: assert property (
    @(posedge clk) disable iff (!nrst)
    (s_q.lock != '0) |=> !fast_osc_tick && $stable(fast_osc_lvl))
    else $error("fast output moved while locking");

  a_trim_gradual: assert property (
    @(posedge clk) disable iff (!nrst)
    (s_q.run && s_q.lock == '0 && $past(s_q.lock) == '0 && $past(s_q.run))
    |-> (s_q.inc - $past(s_q.inc) <= SLEW) || ($past(s_q.inc) - s_q.inc <= SLEW))
    else $error("fast rate jumped on trim change");

  a_sel_legal: assert property (
    @(posedge clk) disable iff (!nrst)
    s_q.cfg_done |-> s_q.sel <= FRQ_MAX)
    else $error("reserved frequency code stored");

  a_src_fixed: assert property (
    @(posedge clk) disable iff (!nrst)
    $past(s_q.cfg_done) |-> $stable(s_q.src))
    else $error("clock source changed after reset");

  a_sys_source: assert property (
    @(posedge clk) disable iff (!nrst)
    sysclk_tick |-> ($past(s_q.tick) && s_q.src != SRC_LF) ||
      ($past(slow_osc_tick) && s_q.src == SRC_LF))
    else $error("system tick from a disallowed source");

  a_conv_rdy_drop: assert property (
    @(posedge clk) disable iff (!nrst)
    (!run_conv) [*4] |-> !s_q.rs2[R_CONV])
    else $error("converter ready seen while stopped");

  a_conv_sleep: assert property (
    @(posedge clk) disable iff (!nrst)
    (conv_rc_req && sleep_mode) [*2] |-> ##[0:260] (conv_rc_tick || !conv_rc_req))
    else $error("converter clock stopped in sleep");

  a_bus_one_wait: assert property (
    @(posedge clk) disable iff (!nrst)
    (req && !s_q.ack) |=> !avs_waitrequest)
    else $error("bus answer not given one cycle after request");

  a_cfg_load: assert property (
    @(posedge clk) disable iff (!nrst)
    !s_q.cfg_done |=> s_q.src == $past(reset_source_config) &&
      s_q.sel == (($past(reset_source_config) == SRC_HF32M) ? FRQ_32M : FRQ_1M))
    else $error("reset configuration not loaded");
endmodule

/* File: tb/ioc_periph_model.sv */
// Peripheral model: raises clock requests and counts the ticks it receives
module ioc_periph_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [6:0] want,
  input wire logic [6:0] ticks,
  output logic [6:0] req,
  output logic [6:0][15:0] cnt
);
  // Requests move only just after an edge and are withdrawn in reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req <= '0;
      cnt <= '0;
    end else begin
      req <= want;
      for (int k = 0; k < 7; k++) begin
        cnt[k] <= cnt[k] + 16'(ticks[k]);
      end
    end
  end
endmodule

/* File: tb/ioc_osc_ctrl_bench.sv */
// Self-checking bench for the internal oscillator control block
module ioc_osc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ioc_pkg::*;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, sleep_mode, lvl, l0;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] strap;
  logic [6:0] want, req, ticks;
  logic [6:0][15:0] cnt, c0;
  int error_cnt, checked, e;
  int d [7];

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ioc_osc_ctrl ioc_osc_ctrl_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reset_source_config(strap), .sleep_mode(sleep_mode), .fast_osc_req(req[0]),
    .mid_osc_req(req[1]), .fixed_osc_req(req[2]), .slow_osc_req(req[3]),
    .powerup_timer_req(req[4]), .watchdog_timer_req(req[5]), .conv_rc_req(req[6]),
    .fast_osc_tick(ticks[0]), .fast_osc_lvl(lvl), .mid_500k_tick(ticks[1]),
    .mid_31k_tick(ticks[2]), .fixed_1mhz_tick(ticks[3]), .slow_osc_tick(ticks[4]),
    .conv_rc_tick(ticks[5]), .sysclk_tick(ticks[6]));

  ioc_periph_model ioc_periph_model_i (.clk(clk), .nrst(nrst), .want(want), .ticks(ticks),
    .req(req), .cnt(cnt));

  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // One Avalon transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, wd};
    avs_write <= wr;
    avs_read <= !wr;
    // Request held until the rising edge that samples waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      finish_test();
    end else begin
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  task automatic rd_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check_val(name, exp, rd);
  endtask

  // Poll one status bit until it reaches v, bounded by tries reads
  task automatic wait_stat(input int b, input logic v, input int tries);
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_STAT, 8'h00);
      n++;
    end while (rd[b] !== v && n < tries);
    check_val("status bit", {31'h0, v}, {31'h0, rd[b]});
  endtask

  task automatic win(input int n);
    c0 = cnt;
    repeat (n) @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      d[k] = int'(cnt[k] - c0[k]);
    end
  endtask

  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    sleep_mode = 1'b0;
    strap = 2'b10;
    want = '0;
    error_cnt = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk("source", IDX_SRC, 32'h0000_0020);
    rd_chk("select", IDX_FRQ, 32'h0000_0000);
    rd_chk("trim", IDX_TRIM, 32'h0000_0000);
    rd_chk("enable", IDX_EN, 32'h0000_0000);
    rd_chk("unmapped", 12'h88f, 32'h0000_0000);
    bus(1'b1, IDX_TRIM, 8'hff);
    rd_chk("trim width", IDX_TRIM, 32'h0000_003f);
    bus(1'b1, IDX_EN, 8'hff);
    rd_chk("enable bits", IDX_EN, 32'h0000_0074);
    bus(1'b1, IDX_EN, 8'h00);
    bus(1'b1, IDX_TRIM, 8'h00);
    bus(1'b1, IDX_SRC, 8'h00);
    rd_chk("source fixed", IDX_SRC, 32'h0000_0020);
    wait_stat(BIT_FAST, 1'b1, 200);
    for (int c = 6; c < 8; c++) begin
      bus(1'b1, IDX_FRQ, 8'(c));
      rd_chk("reserved select", IDX_FRQ, 32'h0000_0000);
      wait_stat(BIT_FAST, 1'b1, 1);
    end
    want <= 7'h7f;
    wait_stat(BIT_SLOW, 1'b1, 2000);
    wait_stat(BIT_MID, 1'b1, 2000);
    wait_stat(BIT_FIXED, 1'b1, 100);
    wait_stat(BIT_CONV, 1'b1, 200);
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        bus(1'b1, IDX_FRQ, 8'h05);
        bus(1'b0, IDX_STAT, 8'h00);
        check_val("ready cleared", 32'h0, {31'h0, rd[BIT_FAST]});
        l0 = lvl;
        win(200);
        check_range("frozen fast", 0, 0, d[0]);
        check_val("frozen level", {31'h0, l0}, {31'h0, lvl});
        wait_stat(BIT_FAST, 1'b1, 200);
      end
      e = 64 << (5 * s);
      win(8000);
      check_range("fast", e - e / 64, e + e / 64, d[0]);
      check_range("mid 500k", 31, 33, d[1]);
      check_range("mid 31k", 1, 3, d[2]);
      check_range("fixed 1M", 63, 65, d[3]);
      check_range("slow", 1, 3, d[4]);
      check_range("conv", 37, 40, d[5]);
      check_range("system", e - e / 64, e + e / 64, d[6]);
    end
    bus(1'b1, IDX_TRIM, 8'h1f);
    repeat (12000) @(posedge clk);
    win(8000);
    check_range("trim max", 2200, 2400, d[0]);
    check_range("slow trimmed", 1, 3, d[4]);
    bus(1'b1, IDX_TRIM, 8'h20);
    win(200);
    check_range("slewing", 54, 60, d[0]);
    wait_stat(BIT_FAST, 1'b1, 1);
    repeat (20000) @(posedge clk);
    win(8000);
    check_range("trim min", 1700, 1880, d[0]);
    sleep_mode <= 1'b1;
    want <= 7'h40;
    wait_stat(BIT_FAST, 1'b0, 20);
    win(2080);
    check_range("fast idle", 0, 0, d[0]);
    check_range("conv in sleep", 9, 11, d[5]);
    want <= 7'h00;
    wait_stat(BIT_CONV, 1'b0, 20);
    bus(1'b1, IDX_EN, 8'h04);
    wait_stat(BIT_CONV, 1'b1, 200);
    bus(1'b1, IDX_EN, 8'h00);
    sleep_mode <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      nrst <= 1'b0;
      strap <= (s == 0) ? 2'b00 : (s == 1) ? 2'b11 : 2'b01;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd_chk("source", IDX_SRC, {26'h000_0000, strap, 4'h0});
      rd_chk("select", IDX_FRQ, (s == 0) ? 32'h0000_0005 : 32'h0000_0000);
      if (s == 1) begin
        win(200);
        check_range("system external", 0, 0, d[6]);
      end
    end
    win(8064);
    check_range("system slow", 1, 3, d[6]);
    check_range("fast unused", 0, 0, d[0]);
    finish_test();
  end
endmodule
